// ---- ssc_cfg.svh ----
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package, the checker and the bench
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
// register offsets (byte addresses on the plain register port)
`define SSC_OFF_TRIG_UPPER   8'h0B
`define SSC_OFF_SAMPLER_CTRL 8'h0C
`define SSC_OFF_STATUS       8'h0F
`define SSC_OFF_CH1_CTRL     8'h10
`define SSC_OFF_EVT_STATUS   8'h30
`define SSC_OFF_EVT_CLEAR    8'h31
`define SSC_OFF_EVT_ENABLE   8'h32
`define SSC_OFF_CHIP_CTRL    8'h33
// sampler control fields
`define SSC_SMP_EN_BIT       7
`define SSC_SMP_MODE_BIT     6
`define SSC_SMP_GAIN_HI      5
`define SSC_SMP_GAIN_LO      4
`define SSC_SMP_TGT_HI       3
`define SSC_SMP_TGT_LO       2
`define SSC_SMP_PTR_HI       1
`define SSC_SMP_PTR_LO       0
// channel one fields
`define SSC_CH1_EN_BIT       7
`define SSC_CH1_SLEEP_BIT    5
`define SSC_CH1_COLOR_BIT    4
`define SSC_CH1_MASK         8'hB0
// status fields
`define SSC_ST_OUT_EN        5
`define SSC_ST_CHIP_EN       4
`define SSC_ST_CLK           3
`define SSC_ST_REF           2
`define SSC_ST_THERM         1
`define SSC_ST_PGOOD         0
// event bits
`define SSC_EV_SAMPLE_DONE   0
`define SSC_EV_TRIG_HIT      1
`define SSC_EV_THERM         2
`define SSC_EV_PGOOD_LOSS    3
`define SSC_EV_MASK          8'h0F
// chip control fields
`define SSC_CHIP_CE_BIT      0
`define SSC_CHIP_OUTEN_BIT   1
// reset values
`define SSC_RST_BYTE         8'h00
`define SSC_RST_PTR          10'h000
// sample timing: one conversion in ns
`define SSC_SAMPLE_NS        200
`define SSC_CLK_NS           50
`define SSC_SAMPLE_CYC       ((`SSC_SAMPLE_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)
`endif

// ---- ssc_pkg.sv ----
// types shared by the sampler status channel control modules
// assumes the constants header sits in the same folder
package ssc_pkg;
    `include "ssc_cfg.svh"
    typedef logic [7:0] ssc_byte_t;   // one register byte
    typedef logic [9:0] ssc_ptr_t;    // trigger pointer / sample value
    typedef enum logic [1:0] {
        SSC_GAIN_QUARTER,
        SSC_GAIN_HALF,
        SSC_GAIN_3QUARTER,
        SSC_GAIN_UNITY
    } ssc_gain_e;
    typedef enum logic [1:0] {
        SSC_TGT_AUX,
        SSC_TGT_CH1,
        SSC_TGT_CH2,
        SSC_TGT_CH3
    } ssc_target_e;
    typedef enum {
        SSC_SMP_IDLE,
        SSC_SMP_CONVERT
    } ssc_smp_state_e;
endpackage

// ---- ssc_regbank.sv ----
// Operation
// - sampler enable bit seven, reset cleared
// - mode set: sample continuously while enabled
// - mode clear: one sample, hardware clears enable
// - gain field bits five-four, default quarter
// - target field bits three-two, default auxiliary
// - compare ten-bit trigger pointer with sample
// - pointer low bits here, high bits upper
// - status five shows output converters enabled
// - status four: pin and register chip-on
// - status three shows internal clock running
// - status two: reference and bias operating
// - status one shows thermal trip exceeded
// - status zero shows supply in range
// - channel one needs enable, chip-on, global enable
// - bit five reduces bias on zero data
// - bit four enables channel one color
// - register chip-on enables chip, reset cleared
//
// register bank top: sampler control, status, channel one control
// assumes a single-cycle register port on clk, status pins asynchronous
`timescale 1ns/1ps
`default_nettype none
module ssc_regbank
    import ssc_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = `SSC_SAMPLE_CYC
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    input  wire logic       chip_on_pin,
    input  wire logic       clk_running_pin,
    input  wire logic       ref_ok_pin,
    input  wire logic       bias_ok_pin,
    input  wire logic       therm_trip_pin,
    input  wire logic       pgood_pin,
    input  wire logic       sample_valid,
    input  wire logic [9:0] sample_value,
    output logic            sampler_on,
    output logic            sample_start,
    output logic      [1:0] sampler_gain,
    output logic      [1:0] sampler_target,
    output logic            channel_one_output_on,
    output logic            ch1_color_on,
    output logic            ch1_auto_sleep,
    output logic            chip_enabled,
    output logic            irq
);
    // register state
    ssc_byte_t smp_ctrl_reg;    // sampler control byte
    ssc_byte_t trig_upper_reg;  // upper trigger pointer bits
    ssc_byte_t ch1_ctrl_reg;    // channel one control byte
    logic      chip_ce_reg;     // register chip-on bit
    logic      outen_reg;       // global output converter enable
    ssc_byte_t evt_reg;         // sticky event bits
    ssc_byte_t evt_en_reg;      // event enables
    ssc_byte_t rdata_reg;       // read data, one cycle after strobe
    logic      therm_d_reg;     // delayed thermal level, edge find
    logic      pgood_d_reg;     // delayed supply level, edge find
    // output registers
    logic        sampler_on_reg, start_reg, ch1_on_reg, color_reg;
    logic        sleep_reg, chip_en_reg, irq_reg;
    logic [1:0]  gain_reg, target_reg;
    // synchronised status levels
    logic [5:0]  st_lvl;
    wire         chip_pin_s, clk_s, ref_s, bias_s, therm_s, pgood_s;
    ssc_smp_if smp ();
    // write decode
    wire wr_smp   = wr_stb && (addr == `SSC_OFF_SAMPLER_CTRL);
    wire wr_trig  = wr_stb && (addr == `SSC_OFF_TRIG_UPPER);
    wire wr_ch1   = wr_stb && (addr == `SSC_OFF_CH1_CTRL);
    wire wr_clr   = wr_stb && (addr == `SSC_OFF_EVT_CLEAR);
    wire wr_en    = wr_stb && (addr == `SSC_OFF_EVT_ENABLE);
    wire wr_chip  = wr_stb && (addr == `SSC_OFF_CHIP_CTRL);
    // status pins through the three-stage synchroniser
    ssc_status_sync #(
        .W      (6)
    ) u_sync (
        .clk    (clk),
        .nrst   (nrst),
        .pin_in ({chip_on_pin, clk_running_pin, ref_ok_pin,
                  bias_ok_pin, therm_trip_pin, pgood_pin}),
        .level  (st_lvl)
    );
    assign chip_pin_s = st_lvl[5];
    assign clk_s      = st_lvl[4];
    assign ref_s      = st_lvl[3];
    assign bias_s     = st_lvl[2];
    assign therm_s    = st_lvl[1];
    assign pgood_s    = st_lvl[0];
    // chip on when pin and register bit both set
    wire chip_on_w = chip_pin_s && chip_ce_reg;
    // output converters on only with chip on and global enable
    wire out_on_w  = chip_on_w && outen_reg;
    // live status byte, reserved top bits zero
    wire [7:0] status_w = {2'b00,
                           out_on_w,
                           chip_on_w,
                           clk_s,
                           ref_s && bias_s,
                           therm_s,
                           pgood_s};
    // sequencer sees the enable, mode and full pointer
    assign smp.enable     = smp_ctrl_reg[`SSC_SMP_EN_BIT];
    assign smp.continuous = smp_ctrl_reg[`SSC_SMP_MODE_BIT];
    assign smp.trig_ptr   = {trig_upper_reg,
                             smp_ctrl_reg[`SSC_SMP_PTR_HI:`SSC_SMP_PTR_LO]};
    ssc_sampler_seq #(
        .SAMPLE_CYC   (SAMPLE_CYC)
    ) u_seq (
        .clk          (clk),
        .nrst         (nrst),
        .smp          (smp),
        .sample_valid (sample_valid),
        .sample_value (sample_value)
    );
    // event sources: sample done, pointer hit, thermal rise, supply fall
    wire [7:0] evt_set_w = {4'h0,
                            pgood_d_reg && !pgood_s,
                            therm_s && !therm_d_reg,
                            smp.trig_hit,
                            smp.done};
    // set wins over a clear written in the same cycle
    wire [7:0] evt_next = ((evt_reg & ~(wr_clr ? wdata : 8'h00)) |
                           evt_set_w) & `SSC_EV_MASK;
    // sampler control next value; hardware clear of enable
    wire [7:0] smp_next = wr_smp ? wdata :
                          (smp.clear_en ?
                           (smp_ctrl_reg & ~(8'h01 << `SSC_SMP_EN_BIT))
                           : smp_ctrl_reg);
    // read mux, unmapped reads zero
    logic [7:0] rd_mux;
    always_comb begin
        unique case (addr)
            `SSC_OFF_SAMPLER_CTRL: rd_mux = smp_ctrl_reg;
            `SSC_OFF_TRIG_UPPER:   rd_mux = trig_upper_reg;
            `SSC_OFF_STATUS:       rd_mux = status_w;
            `SSC_OFF_CH1_CTRL:     rd_mux = ch1_ctrl_reg;
            `SSC_OFF_EVT_STATUS:   rd_mux = evt_reg;
            `SSC_OFF_EVT_ENABLE:   rd_mux = evt_en_reg;
            `SSC_OFF_CHIP_CTRL:    rd_mux = {6'h00, outen_reg, chip_ce_reg};
            default:               rd_mux = 8'h00;
        endcase
    end
    // software registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            smp_ctrl_reg   <= `SSC_RST_BYTE;   // enable cleared
            trig_upper_reg <= `SSC_RST_BYTE;
            ch1_ctrl_reg   <= `SSC_RST_BYTE;
            chip_ce_reg    <= 1'b0;
            outen_reg      <= 1'b0;
            evt_en_reg     <= `SSC_RST_BYTE;
        end else begin
            smp_ctrl_reg <= smp_next;
            if (wr_trig) begin
                trig_upper_reg <= wdata;
            end
            if (wr_ch1) begin
                ch1_ctrl_reg <= wdata & `SSC_CH1_MASK;
            end
            if (wr_chip) begin
                chip_ce_reg <= wdata[`SSC_CHIP_CE_BIT];
                outen_reg   <= wdata[`SSC_CHIP_OUTEN_BIT];
            end
            if (wr_en) begin
                evt_en_reg <= wdata & `SSC_EV_MASK;
            end
        end
    end
    // event flags, edge history and read data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            evt_reg     <= `SSC_RST_BYTE;
            therm_d_reg <= 1'b0;
            pgood_d_reg <= 1'b0;
            rdata_reg   <= `SSC_RST_BYTE;
        end else begin
            evt_reg     <= evt_next;
            therm_d_reg <= therm_s;
            pgood_d_reg <= pgood_s;
            rdata_reg   <= rd_stb ? rd_mux : 8'h00;
        end
    end
    // registered outputs driving the analog controls
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sampler_on_reg <= 1'b0;
            start_reg      <= 1'b0;
            gain_reg       <= 2'b00;
            target_reg     <= 2'b00;
            ch1_on_reg     <= 1'b0;
            color_reg      <= 1'b0;
            sleep_reg      <= 1'b0;
            chip_en_reg    <= 1'b0;
            irq_reg        <= 1'b0;
        end else begin
            sampler_on_reg <= smp.enable;
            start_reg      <= smp.sample_req;
            gain_reg   <= smp_ctrl_reg[`SSC_SMP_GAIN_HI:`SSC_SMP_GAIN_LO];
            target_reg <= smp_ctrl_reg[`SSC_SMP_TGT_HI:`SSC_SMP_TGT_LO];
            // gain and target codes pass straight through
            ch1_on_reg <= ch1_ctrl_reg[`SSC_CH1_EN_BIT] && out_on_w;
            color_reg  <= ch1_ctrl_reg[`SSC_CH1_COLOR_BIT];
            sleep_reg  <= ch1_ctrl_reg[`SSC_CH1_SLEEP_BIT];
            chip_en_reg <= chip_on_w;
            irq_reg     <= |(evt_next & evt_en_reg);
        end
    end
    assign rdata                 = rdata_reg;
    assign sampler_on            = sampler_on_reg;
    assign sample_start          = start_reg;
    assign sampler_gain          = gain_reg;
    assign sampler_target        = target_reg;
    assign channel_one_output_on = ch1_on_reg;
    assign ch1_color_on          = color_reg;
    assign ch1_auto_sleep        = sleep_reg;
    assign chip_enabled          = chip_en_reg;
    assign irq                   = irq_reg;
endmodule
`default_nettype wire

// ---- ssc_regbank_assertions.sv ----
// checker for the register bank top: field copies, gating, sampler pacing
// assumes the constants header; bound to every ssc_regbank instance
`timescale 1ns/1ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_regbank_checker
    import ssc_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = 4  // conversion timeout, cycles
) (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rdata,
    input wire logic       sampler_on,
    input wire logic       sample_start,
    input wire logic [1:0] sampler_gain,
    input wire logic [1:0] sampler_target,
    input wire logic       channel_one_output_on,
    input wire logic       ch1_color_on,
    input wire logic       ch1_auto_sleep,
    input wire logic       chip_enabled,
    input wire logic       irq
);
    // longest wait between two starts of a continuous run
    localparam int RESTART_MAX = SAMPLE_CYC * 4 + 8;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // write to the sampler control register, then the two arming forms
    sequence s_smp_wr;
        wr_stb && addr == `SSC_OFF_SAMPLER_CTRL;
    endsequence
    sequence s_single_arm;
        s_smp_wr ##0 wdata[7:6] == 2'h2;
    endsequence
    sequence s_cont_arm;
        s_smp_wr ##0 wdata[7:6] == 2'h3;
    endsequence
    // first start lands three edges after the arming write
    sequence s_first_start;
        ##2 sample_start;
    endsequence
    chk_enable_copy: assert property (
        s_smp_wr |=> ##1 sampler_on == $past(wdata[7], 2))
        else $error("sampler_on does not follow the written enable bit");
    chk_gain_target: assert property (
        s_smp_wr |=> ##1 {sampler_gain, sampler_target} == $past(wdata[5:2], 2))
        else $error("gain or target code does not follow the write");
    chk_ch1_bits: assert property (
        wr_stb && addr == `SSC_OFF_CH1_CTRL |=> ##1
        {ch1_auto_sleep, ch1_color_on} == $past(wdata[5:4], 2))
        else $error("channel one sleep or color enable does not follow");
    chk_ch1_reserved: assert property (
        rd_stb && addr == `SSC_OFF_CH1_CTRL |=> (rdata & 8'h4F) == 8'h00)
        else $error("reserved channel one bits read nonzero");
    chk_ch1_gate: assert property (
        channel_one_output_on |-> chip_enabled)
        else $error("channel one active without chip enable");
    chk_start_needs_en: assert property (
        sample_start |-> sampler_on)
        else $error("conversion started with the sampler off");
    chk_irq_mask_all: assert property (
        wr_stb && addr == `SSC_OFF_EVT_ENABLE && wdata == 8'h00 |=> ##1 !irq)
        else $error("irq high with every event masked");
    chk_cont_restart: assert property (
        s_cont_arm |=> s_first_start ##[2:RESTART_MAX] sample_start)
        else $error("continuous run did not restart");
    chk_single_once: assert property (
        s_single_arm |=> s_first_start ##1 (!sample_start)[*8])
        else $error("single shot started more than one conversion");
endmodule
bind ssc_regbank ssc_regbank_checker #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .sampler_on(sampler_on), .sample_start(sample_start),
    .sampler_gain(sampler_gain), .sampler_target(sampler_target),
    .channel_one_output_on(channel_one_output_on),
    .ch1_color_on(ch1_color_on), .ch1_auto_sleep(ch1_auto_sleep),
    .chip_enabled(chip_enabled), .irq(irq)
);
`default_nettype wire

// ---- ssc_regbank_tb.sv ----
// self-checking bench for the sampler status channel register bank
// assumes package, constants header and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_regbank_tb
    import ssc_pkg::*;
;
    logic        clk = 1'h0;          // 20 MHz clock
    logic        nrst = 1'h0;         // synchronous reset, low
    ssc_byte_t   addr = 8'h00;        // register address
    ssc_byte_t   wdata = 8'h00;       // write data
    logic        wr_stb = 1'h0;       // write strobe
    logic        rd_stb = 1'h0;       // read strobe
    logic [5:0]  pins = 6'h00;        // chip-on clk ref bias therm pgood
    logic        sample_valid = 1'h0; // conversion result strobe
    ssc_ptr_t    sample_value = 10'h000;
    wire logic [7:0] rdata;           // read data
    wire logic [1:0] gain, tgt;       // sampler gain and target
    wire logic   smp_on, start, ch1_on, color, sleep, chip_en, irq;
    wire logic [5:0] lv = {smp_on, ch1_on, color, sleep, chip_en, irq};
    logic [15:0] exp_q[$];            // pending reads: address, byte
    logic [15:0] note;                // oldest pending read
    logic        rd_seen = 1'h0;      // read data due this cycle
    int mismatches = 0, checks_done = 0, cycles = 0, starts = 0;
    int seed = 72, s0, s1, n;
    ssc_byte_t   v;                   // random register byte
    ssc_regbank #(.SAMPLE_CYC(4)) dut (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .chip_on_pin(pins[5]), .clk_running_pin(pins[4]),
        .ref_ok_pin(pins[3]), .bias_ok_pin(pins[2]),
        .therm_trip_pin(pins[1]), .pgood_pin(pins[0]),
        .sample_valid(sample_valid), .sample_value(sample_value),
        .sampler_on(smp_on), .sample_start(start),
        .sampler_gain(gain), .sampler_target(tgt),
        .channel_one_output_on(ch1_on), .ch1_color_on(color),
        .ch1_auto_sleep(sleep), .chip_enabled(chip_en), .irq(irq)
    );
    always #25 clk = ~clk;
    // count a comparison and report it when it differs
    task automatic cmp(input string w, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one-cycle strobes, entered just after a rising edge
    task automatic wr(input ssc_byte_t a, input ssc_byte_t d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'h1;
        rd_stb <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(input ssc_byte_t a, input ssc_byte_t e);
        exp_q.push_back({a, e});
        addr <= a;
        wr_stb <= 1'h0;
        rd_stb <= 1'h1;
        @(posedge clk);
    endtask
    // drop the strobes, let n edges pass; settle ends mid-cycle
    task automatic idle(input int n);
        wr_stb <= 1'h0;
        rd_stb <= 1'h0;
        repeat (n) @(posedge clk);
    endtask
    task automatic settle(input int n);
        idle(n);
        @(negedge clk);
    endtask
    // watcher: read data, conversion starts and the run limit
    always @(posedge clk) begin
        if (rd_seen) begin
            note = exp_q.pop_front();
            cmp("rdata", {note[15:8], note[7:0]}, {note[15:8], rdata});
        end
        rd_seen <= rd_stb;
        if (start === 1'h1)
            starts <= starts + 1;
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        settle(1);
        cmp("levels after reset", 16'h0000, 16'(lv));
        @(posedge clk);
        rd(`SSC_OFF_SAMPLER_CTRL, 8'h00);
        rd(`SSC_OFF_CH1_CTRL, 8'h00);
        rd(`SSC_OFF_CHIP_CTRL, 8'h00);
        rd(8'h55, 8'h00);
        // every gain and target code with random pointer bits
        for (int i = 0; i < 16; i++) begin
            v = 8'($random(seed));
            v[7:2] = {2'h0, 4'(i)};
            wr(`SSC_OFF_SAMPLER_CTRL, v);
            wr(`SSC_OFF_TRIG_UPPER, ~v);
            rd(`SSC_OFF_SAMPLER_CTRL, v);
            rd(`SSC_OFF_TRIG_UPPER, ~v);
            settle(1);
            cmp("sampler_gain", 16'(v[5:4]), 16'(gain));
            cmp("sampler_target", 16'(v[3:2]), 16'(tgt));
            @(posedge clk);
        end
        wr(`SSC_OFF_CH1_CTRL, 8'hFF);
        rd(`SSC_OFF_CH1_CTRL, `SSC_CH1_MASK);
        settle(2);
        cmp("channel one", 16'h000C, 16'(lv));
        @(posedge clk);
        // live status against random pin levels, register chip-on and global enable set
        wr(`SSC_OFF_CHIP_CTRL, 8'h03);
        for (int i = 0; i < 10; i++) begin
            pins <= 6'($random(seed));
            settle(6);
            cmp("gating", {10'h000, 1'h0, pins[5], 2'h3, pins[5], 1'h0},
                16'(lv));
            @(posedge clk);
            rd(`SSC_OFF_STATUS,
               {2'h0, pins[5], pins[5], pins[4], pins[3] & pins[2],
                pins[1:0]});
        end
        // register chip-on and global enable in all four combinations
        pins <= 6'h3F;
        for (int k = 0; k < 4; k++) begin
            wr(`SSC_OFF_CHIP_CTRL, 8'(k));
            wr(`SSC_OFF_STATUS, 8'h00);
            settle(6);
            cmp("channel_one_output_on", 16'(k == 3), 16'(ch1_on));
            @(posedge clk);
            rd(`SSC_OFF_STATUS,
               {2'h0, k == 3, k[0], 4'hF});
        end
        // single shots: one sample below the pointer, one equal to it
        wr(`SSC_OFF_TRIG_UPPER, 8'h10);
        wr(`SSC_OFF_EVT_ENABLE, 8'h0F);
        for (int k = 0; k < 2; k++) begin
            wr(`SSC_OFF_EVT_CLEAR, 8'hFF);
            wr(`SSC_OFF_SAMPLER_CTRL, 8'h80);
            s0 = starts;
            idle(0);
            for (n = 0; n < 8 && start !== 1'h1; n++) @(posedge clk);
            sample_value <= 10'h03F + 10'(k);
            sample_valid <= 1'h1;
            @(posedge clk);
            sample_valid <= 1'h0;
            sample_value <= ~sample_value;
            idle(8);
            rd(`SSC_OFF_SAMPLER_CTRL, 8'h00);
            rd(`SSC_OFF_EVT_STATUS, 8'(k * 2 + 1));
            settle(1);
            cmp("single starts", 16'h0001, 16'(starts - s0));
            cmp("irq and sampler_on", 16'h0001, 16'(lv) & 16'h0021);
            @(posedge clk);
        end
        // mask, unmask, then clear the pending events
        wr(`SSC_OFF_EVT_ENABLE, 8'h00);
        settle(2);
        cmp("irq masked", 16'h0000, 16'(irq));
        @(posedge clk);
        wr(`SSC_OFF_EVT_ENABLE, 8'h0F);
        settle(2);
        cmp("irq unmasked", 16'h0001, 16'(irq));
        @(posedge clk);
        wr(`SSC_OFF_EVT_CLEAR, 8'h03);
        rd(`SSC_OFF_EVT_STATUS, 8'h00);
        settle(2);
        cmp("irq cleared", 16'h0000, 16'(irq));
        @(posedge clk);
        // continuous run restarts until software clears the enable
        s0 = starts;
        wr(`SSC_OFF_SAMPLER_CTRL, 8'hC0);
        idle(30);
        wr(`SSC_OFF_SAMPLER_CTRL, 8'h40);
        idle(10);
        s1 = starts;
        rd(`SSC_OFF_SAMPLER_CTRL, 8'h40);
        settle(20);
        cmp("restarts", 16'h0001, 16'(s1 - s0 >= 3));
        cmp("starts after stop", 16'(s1), 16'(starts));
        final_report();
    end
endmodule
`default_nettype wire

// ---- ssc_sampler_seq.sv ----
// sampler sequencer: paces conversions and compares against the pointer
// assumes sample_value is valid with sample_valid on the same clock
`timescale 1ns/1ps
`default_nettype none
module ssc_sampler_seq
    import ssc_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = `SSC_SAMPLE_CYC
) (
    input  wire logic  clk,
    input  wire logic  nrst,
    ssc_smp_if.seq     smp,
    input  wire logic  sample_valid,
    input  wire logic [9:0] sample_value
);
    ssc_smp_state_e state_reg, state_next;   // sequencer state
    logic [15:0]    cnt_reg, cnt_next;       // conversion timeout
    logic           done_reg, hit_reg, clr_reg, req_reg;
    wire            finish;                  // conversion ends now
    wire            cnt_out;
    assign cnt_out = (cnt_reg == 16'(SAMPLE_CYC - 1));
    assign finish  = (state_reg == SSC_SMP_CONVERT) &&
                     (sample_valid || cnt_out);
    // next state: run while enabled, one sample then stop in single shot
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            SSC_SMP_IDLE: begin
                cnt_next = 16'h0000;
                // a pending single-shot clear must not re-arm
                if (smp.enable && !clr_reg) begin
                    state_next = SSC_SMP_CONVERT;
                end
            end
            SSC_SMP_CONVERT: begin
                cnt_next = cnt_reg + 16'h0001;
                if (!smp.enable) begin  // sampler switched off
                    state_next = SSC_SMP_IDLE;
                end else if (finish) begin
                    cnt_next = 16'h0000;
                    // continuous keeps going, single shot returns
                    state_next = smp.continuous ? SSC_SMP_CONVERT
                                                : SSC_SMP_IDLE;
                end
            end
        endcase
    end
    // state and pulse registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= SSC_SMP_IDLE;
            cnt_reg   <= 16'h0000;
            done_reg  <= 1'b0;
            hit_reg   <= 1'b0;
            clr_reg   <= 1'b0;
            req_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            done_reg  <= finish && smp.enable;
            // compare sample against the trigger pointer
            hit_reg   <= finish && smp.enable && sample_valid &&
                         (sample_value >= smp.trig_ptr);
            // single shot: hardware clears the enable
            clr_reg   <= finish && smp.enable && !smp.continuous;
            req_reg   <= (state_next == SSC_SMP_CONVERT) &&
                         (state_reg == SSC_SMP_IDLE || finish);
        end
    end
    assign smp.done       = done_reg;
    assign smp.trig_hit   = hit_reg;
    assign smp.clear_en   = clr_reg;
    assign smp.sample_req = req_reg;
    assign smp.busy       = (state_reg == SSC_SMP_CONVERT);
endmodule
`default_nettype wire

// ---- ssc_smp_if.sv ----
// carrier between the register bank and the sampler sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface ssc_smp_if;
    import ssc_pkg::*;
    logic        enable;      // sampler enable bit
    logic        continuous;  // sampling mode bit
    ssc_ptr_t    trig_ptr;    // full trigger pointer
    logic        done;        // one sample finished, pulse
    logic        clear_en;    // single shot ends, clear enable, pulse
    logic        trig_hit;    // sample reached pointer, pulse
    logic        busy;        // conversion in progress
    logic        sample_req;  // start a conversion, pulse
    modport bank (output enable, continuous, trig_ptr,
                  input done, clear_en, trig_hit, busy, sample_req);
    modport seq  (input enable, continuous, trig_ptr,
                  output done, clear_en, trig_hit, busy, sample_req);
endinterface
`default_nettype wire

// ---- ssc_status_sync.sv ----
// three-stage synchroniser for the status pins
// assumes the pins are asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module ssc_status_sync #(
    parameter int unsigned W = 5
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg;  // flip-flop chain
    logic [W-1:0] level_reg;               // filtered level
    // change counts once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    s1_reg[i]    <= 1'b0;
                    s2_reg[i]    <= 1'b0;
                    s3_reg[i]    <= 1'b0;
                    level_reg[i] <= 1'b0;
                end else begin
                    s1_reg[i] <= pin_in[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        level_reg[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate
    assign level = level_reg;
endmodule
`default_nettype wire
